//--- rtl/drive_monitor_config_objects.v
// Object bank of a motor drive: supply/temperature readouts, brake-resistor
// control, loader identity, last error mirror and the drive control word.
// Assumes a master on ref_clk issuing one-cycle index/subindex requests.
//
// Function
// - Subentry 1 reports power supply voltage, signed 32-bit millivolts, read-only.
// - Subentry 2 reports logic supply voltage, signed 32-bit millivolts, read-only.
// - Subentry 3 reports board temperature in signed tenths of a degree.
// - Subentries 4 and 5 report motor and MCU temperature, read-only signed values.
// - Readouts start at zero, device-updated, never saved.
// - Ballast settings bit 0 enables the brake resistor; default enabled.
// - Ballast limit in millivolts, read/write, default 0000EBBF.
// - Ballast hysteresis in millivolts, read/write, default 000001F4.
// - Ballast entries belong to the tuning save group; save_settings_tuning mirrors only the settings word.
// - Loader version: major in upper half, minor in lower half.
// - Loader fieldbus word uses the fieldbus availability bit layout.
// - Loader object has three read-only words; count reads three.
// - Last error code equals low 16 bits of newest history entry.
// - Last error code read-only 16-bit, zero after start-up.
// - Control word read/write 16-bit, default zero, commands state machine.
// - Serial number is a read-only string, not mappable.
// - Device identifier is a read-only octet string, not mappable.
// - Setting the fault-reset control bit clears a pending error.
`include "drive_objects_consts.vh"

module drive_monitor_config_objects (
    input wire ref_clk,
    input wire rst,
    input wire req_valid,
    input wire req_write,
    input wire [15:0] req_index,
    input wire [7:0] req_subindex,
    input wire [31:0] req_wdata,
    output reg rsp_valid,
    output reg rsp_error,
    output reg [31:0] rsp_rdata,
    input wire [31:0] power_supply_voltage,
    input wire [31:0] logic_supply_voltage,
    input wire [31:0] board_temperature,
    input wire [31:0] motor_temperature,
    input wire [31:0] mcu_temperature,
    input wire [31:0] loader_version,
    input wire [31:0] loader_fieldbus,
    input wire [31:0] loader_hardware_group,
    input wire [31:0] serial_number,
    input wire [31:0] device_identifier,
    input wire error_push,
    input wire [31:0] error_entry,
    output reg [15:0] drive_control_word,
    output reg fault_clear_pulse,
    output reg brake_resistor_on,
    output reg [31:0] save_settings_tuning
);
    // Readouts are plain inputs on ref_clk; the monitor logic is assumed synchronous.
    reg [31:0] opcond_r [1:5];
    reg [31:0] ballast_settings_r;
    reg [31:0] brake_resistor_limit_r;
    reg [31:0] brake_resistor_hysteresis_r;
    reg [15:0] last_error_r;
    reg [15:0] ctrl_r;
    reg [31:0] rdata_nxt;
    reg err_nxt;
    reg [32:0] off_level;
    wire wr;
    wire [31:0] opcond_in [1:5];
    reg wr_settings;
    reg wr_limit;
    reg wr_hyst;
    reg wr_ctrl;
    wire fault_clear_edge;

    assign wr = req_valid & req_write;
    assign fault_clear_edge = wr_ctrl & req_wdata[`FAULT_CLEAR_BIT] & ~ctrl_r[`FAULT_CLEAR_BIT];
    assign opcond_in[1] = power_supply_voltage;
    assign opcond_in[2] = logic_supply_voltage;
    assign opcond_in[3] = board_temperature;
    assign opcond_in[4] = motor_temperature;
    assign opcond_in[5] = mcu_temperature;

    genvar g;
    generate
        for (g = 1; g <= 5; g = g + 1) begin : g_opcond
            always @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    opcond_r[g] <= `ZERO32;
                end else begin
                    opcond_r[g] <= opcond_in[g];
                end
            end
        end
    endgenerate

    // One decode feeds every write, so a refused write can never touch state
    always @* begin
        wr_settings = 1'b0;
        wr_limit = 1'b0;
        wr_hyst = 1'b0;
        wr_ctrl = 1'b0;
        if (wr) begin
            case (req_index)
                `IDX_BALLAST_CONFIGURATION: begin
                    case (req_subindex)
                        `SUB_1: begin
                            wr_settings = 1'b1;
                        end
                        `SUB_2: begin
                            wr_limit = 1'b1;
                        end
                        `SUB_3: begin
                            wr_hyst = 1'b1;
                        end
                        default: begin
                            wr_settings = 1'b0;
                        end
                    endcase
                end
                `IDX_DRIVE_CONTROL_WORD: begin
                    wr_ctrl = (req_subindex == `SUB_COUNT);
                end
                default: begin
                    wr_ctrl = 1'b0;
                end
            endcase
        end
    end

    // Ballast registers and control word
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ballast_settings_r <= `BALLAST_SETTINGS_RST;
            brake_resistor_limit_r <= `BALLAST_LIMIT_RST;
            brake_resistor_hysteresis_r <= `BALLAST_HYST_RST;
            ctrl_r <= `ZERO16;
        end else begin
            if (wr_settings) begin
                ballast_settings_r <= req_wdata;
            end
            if (wr_limit) begin
                brake_resistor_limit_r <= req_wdata;
            end
            if (wr_hyst) begin
                brake_resistor_hysteresis_r <= req_wdata;
            end
            if (wr_ctrl) begin
                ctrl_r <= req_wdata[15:0];
            end
        end
    end

    // A push in the same cycle as a fault clear wins, so no error is lost.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            last_error_r <= `ZERO16;
        end else if (error_push) begin
            last_error_r <= error_entry[15:0];
        end else if (fault_clear_edge) begin
            last_error_r <= `ZERO16;
        end
    end

    always @* begin
        if (brake_resistor_hysteresis_r > brake_resistor_limit_r) begin
            off_level = {1'b0, `ZERO32};
        end else begin
            off_level = {1'b0, brake_resistor_limit_r - brake_resistor_hysteresis_r};
        end
    end

    // Comparisons are unsigned; a negative supply reading is treated as below threshold.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            brake_resistor_on <= 1'b0;
        end else if (!ballast_settings_r[`BALLAST_ENABLE_BIT]) begin
            brake_resistor_on <= 1'b0;
        end else if (opcond_r[1][31]) begin
            brake_resistor_on <= 1'b0;
        end else if (opcond_r[1] > brake_resistor_limit_r) begin
            brake_resistor_on <= 1'b1;
        end else if ({1'b0, opcond_r[1]} < off_level) begin
            brake_resistor_on <= 1'b0;
        end
    end

    // Read decode
    always @* begin
        rdata_nxt = `ZERO32;
        err_nxt = 1'b0;
        case (req_index)
            `IDX_OPERATING_CONDITIONS: begin
                if (req_write) begin
                    err_nxt = 1'b1;
                end else if (req_subindex == `SUB_COUNT) begin
                    rdata_nxt = `OPCOND_ENTRIES;
                end else if (req_subindex == `SUB_1) begin
                    rdata_nxt = opcond_r[1];
                end else if (req_subindex == `SUB_2) begin
                    rdata_nxt = opcond_r[2];
                end else if (req_subindex == `SUB_3) begin
                    rdata_nxt = opcond_r[3];
                end else if (req_subindex == `SUB_4) begin
                    rdata_nxt = opcond_r[4];
                end else if (req_subindex == `SUB_5) begin
                    rdata_nxt = opcond_r[5];
                end else begin
                    err_nxt = 1'b1;
                end
            end
            `IDX_BALLAST_CONFIGURATION: begin
                if (req_subindex == `SUB_COUNT) begin
                    rdata_nxt = `BALLAST_ENTRIES;
                    err_nxt = req_write;
                end else if (req_subindex == `SUB_1) begin
                    rdata_nxt = ballast_settings_r;
                end else if (req_subindex == `SUB_2) begin
                    rdata_nxt = brake_resistor_limit_r;
                end else if (req_subindex == `SUB_3) begin
                    rdata_nxt = brake_resistor_hysteresis_r;
                end else begin
                    err_nxt = 1'b1;
                end
            end
            `IDX_SERIAL_NUMBER: begin
                rdata_nxt = serial_number;
                err_nxt = req_write | (req_subindex != `SUB_COUNT);
            end
            `IDX_DEVICE_ID: begin
                rdata_nxt = device_identifier;
                err_nxt = req_write | (req_subindex != `SUB_COUNT);
            end
            `IDX_LOADER_INFORMATION: begin
                if (req_write) begin
                    err_nxt = 1'b1;
                end else if (req_subindex == `SUB_COUNT) begin
                    rdata_nxt = `LOADER_ENTRIES;
                end else if (req_subindex == `SUB_1) begin
                    rdata_nxt = {loader_version[`LOADER_MAJOR_HI:`LOADER_MAJOR_LO],
                                 loader_version[`LOADER_MINOR_HI:`LOADER_MINOR_LO]};
                end else if (req_subindex == `SUB_2) begin
                    rdata_nxt = loader_fieldbus;
                end else if (req_subindex == `SUB_3) begin
                    rdata_nxt = loader_hardware_group;
                end else begin
                    err_nxt = 1'b1;
                end
            end
            `IDX_LAST_ERROR_CODE: begin
                rdata_nxt = {`ZERO16, last_error_r};
                err_nxt = req_write | (req_subindex != `SUB_COUNT);
            end
            `IDX_DRIVE_CONTROL_WORD: begin
                rdata_nxt = {`ZERO16, ctrl_r};
                err_nxt = (req_subindex != `SUB_COUNT);
            end
            default: begin
                err_nxt = 1'b1;
            end
        endcase
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_error <= 1'b0;
            rsp_rdata <= `ZERO32;
            fault_clear_pulse <= 1'b0;
            drive_control_word <= `ZERO16;
            save_settings_tuning <= `ZERO32;
        end else begin
            rsp_valid <= req_valid;
            rsp_error <= req_valid & err_nxt;
            rsp_rdata <= (req_valid && !req_write && !err_nxt) ? rdata_nxt : `ZERO32;
            fault_clear_pulse <= fault_clear_edge;
            drive_control_word <= ctrl_r;
            save_settings_tuning <= ballast_settings_r;
        end
    end
endmodule

//--- rtl/drive_objects_consts.vh
// Object dictionary constants for the drive monitor/config object bank
// Assumes inclusion by bare name from the design file
`ifndef DRIVE_OBJECTS_CONSTS_VH
`define DRIVE_OBJECTS_CONSTS_VH
`define IDX_OPERATING_CONDITIONS 16'h4014
`define IDX_BALLAST_CONFIGURATION 16'h4021
`define IDX_SERIAL_NUMBER 16'h4040
`define IDX_DEVICE_ID 16'h4041
`define IDX_LOADER_INFORMATION 16'h4042
`define IDX_LAST_ERROR_CODE 16'h603F
`define IDX_DRIVE_CONTROL_WORD 16'h6040
`define SUB_COUNT 8'h00
`define SUB_1 8'h01
`define SUB_2 8'h02
`define SUB_3 8'h03
`define SUB_4 8'h04
`define SUB_5 8'h05
`define OPCOND_ENTRIES 32'h00000005
`define BALLAST_ENTRIES 32'h00000003
`define LOADER_ENTRIES 32'h00000003
`define ZERO32 32'h00000000
`define ZERO16 16'h0000
`define BALLAST_SETTINGS_RST 32'h00000001
`define BALLAST_LIMIT_RST 32'h0000EBBF
`define BALLAST_HYST_RST 32'h000001F4
`define BALLAST_ENABLE_BIT 0
`define FAULT_CLEAR_BIT 7
`define LOADER_MAJOR_HI 31
`define LOADER_MAJOR_LO 16
`define LOADER_MINOR_HI 15
`define LOADER_MINOR_LO 0
`define SYNC_DEPTH 3
`endif

//--- bench/drive_objects_sva.sv
// Checker of the drive object bank port relations.
// Assumes one clock and an asynchronous active-high reset; bound from tb.
module drive_objects_sva (
    input wire logic ref_clk, rst, req_valid, req_write, rsp_valid, rsp_error,
    input wire logic fault_clear_pulse, brake_resistor_on,
    input wire logic [7:0] req_subindex,
    input wire logic [15:0] req_index, drive_control_word,
    input wire logic [31:0] req_wdata, rsp_rdata, power_supply_voltage
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_cw_wr;
        req_valid && req_write && req_index == 16'h6040 && req_subindex == 8'h00;
    endsequence
    // Copy output lags one cycle, so a write in the previous cycle hides the new bit
    sequence s_fclr_set; s_cw_wr ##0 (req_wdata[7] && !drive_control_word[7] && !$past(req_valid)); endsequence
    property p_answer; req_valid |=> rsp_valid; endproperty
    a_answer: assert property (p_answer) else $error("late response");
    property p_idle; !req_valid |=> !rsp_valid; endproperty
    a_idle: assert property (p_idle) else $error("stray response");
    property p_ro; req_valid && req_write && req_index == 16'h4014 |=> rsp_error; endproperty
    a_ro: assert property (p_ro) else $error("readout write taken");
    property p_err_hi; req_valid && !req_write && req_index == 16'h603F |=> !rsp_rdata[31:16]; endproperty
    a_err_hi: assert property (p_err_hi) else $error("error code wider than 16 bits");
    property p_wr_zero; req_valid && req_write |=> rsp_rdata == 32'h00000000; endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("write returned data");
    property p_cw; s_cw_wr |=> ##1 drive_control_word == $past(req_wdata[15:0], 2); endproperty
    a_cw: assert property (p_cw) else $error("control word not stored");
    property p_fclr; s_fclr_set |=> fault_clear_pulse; endproperty
    a_fclr: assert property (p_fclr) else $error("fault clear missing");
    property p_fclr_cause; fault_clear_pulse |-> $past(req_valid && req_write
        && req_index == 16'h6040 && req_subindex == 8'h00 && req_wdata[7]); endproperty
    a_fclr_cause: assert property (p_fclr_cause) else $error("fault clear without write");
    property p_brake_neg; $past(power_supply_voltage[31]) && $past(power_supply_voltage[31], 2)
        |-> !brake_resistor_on; endproperty
    a_brake_neg: assert property (p_brake_neg) else $error("brake on at negative supply");
endmodule

//--- bench/field_master.sv
// Fieldbus master model: one indexed access at a time.
// Assumes the answer is registered and comes one cycle after the request.
module field_master (
    input wire logic ref_clk, rsp_valid, rsp_error,
    input wire logic [31:0] rsp_rdata,
    output logic req_valid = 1'b0,
    output logic req_write = 1'b0,
    output logic [15:0] req_index = 16'h0000,
    output logic [7:0] req_subindex = 8'h00,
    output logic [31:0] req_wdata = 32'h00000000
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
            input logic [31:0] wd, output logic [31:0] rd, output logic err);
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_index <= idx;
        req_subindex <= sub;
        req_wdata <= wd;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        // Released index and data lines change so a stale value is never trusted
        req_index <= ~idx;
        req_wdata <= ~wd;
        #1;
        err = rsp_error;
        rd = rsp_valid ? rsp_rdata : ~rsp_rdata;
    endtask
endmodule

//--- bench/tb.sv
// Testbench of the drive object bank: table of accesses, then brake,
// error mirror, control word and reset cases.
// Assumes the design, field_master and drive_objects_sva are compiled first.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic w; logic [15:0] i; logic [7:0] s; logic [31:0] x; logic e;} row_t;
    row_t rows[16] = '{'{1'b0, 16'h4014, 8'h01, 32'h0000F000, 1'b0},
        '{1'b0, 16'h4014, 8'h04, 32'h00000190, 1'b0},
        '{1'b0, 16'h4014, 8'h02, 32'h00005DC0, 1'b0}, '{1'b0, 16'h4014, 8'h03, 32'hFFFFFF9C, 1'b0},
        '{1'b0, 16'h4014, 8'h05, 32'h000001A4, 1'b0}, '{1'b1, 16'h4014, 8'h04, 32'h00000000, 1'b1},
        '{1'b0, 16'h4014, 8'h00, 32'h00000005, 1'b0}, '{1'b0, 16'h4021, 8'h01, 32'h00000001, 1'b0},
        '{1'b0, 16'h4021, 8'h02, 32'h0000EBBF, 1'b0}, '{1'b0, 16'h4021, 8'h03, 32'h000001F4, 1'b0},
        '{1'b0, 16'h4042, 8'h00, 32'h00000003, 1'b0}, '{1'b0, 16'h4042, 8'h01, 32'h00040002, 1'b0},
        '{1'b0, 16'h4042, 8'h02, 32'h00000005, 1'b0}, '{1'b0, 16'h4042, 8'h03, 32'h00000007, 1'b0},
        '{1'b0, 16'h4040, 8'h00, 32'h1234ABCD, 1'b0}, '{1'b1, 16'h603F, 8'h00, 32'h00000000, 1'b1}};
    logic ref_clk, rst = 1'b1, error_push = 1'b0;
    logic [31:0] power_supply_voltage = 32'h0000F000, logic_supply_voltage = 32'h00005DC0;
    logic [31:0] board_temperature = 32'hFFFFFF9C, motor_temperature = 32'h00000190;
    logic [31:0] mcu_temperature = 32'h000001A4, loader_version = 32'h00040002;
    logic [31:0] loader_fieldbus = 32'h00000005, loader_hardware_group = 32'h00000007;
    logic [31:0] serial_number = 32'h1234ABCD, device_identifier = 32'h0000C0DE; // Arbitrary
    logic [31:0] error_entry = 32'h00000000, rd, save_settings_tuning, rsp_rdata, req_wdata;
    logic [15:0] req_index, drive_control_word;
    logic [7:0] req_subindex;
    logic req_valid, req_write, rsp_valid, rsp_error, er, fault_clear_pulse, brake_resistor_on;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    drive_monitor_config_objects u_dut (.*);
    field_master u_master (.*);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("Checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
        u_master.access(w, i, s, d, rd, er);
    endtask
    task automatic pwr_step(input logic [31:0] v, input logic exp);
        @(posedge ref_clk);
        power_supply_voltage <= v;
        repeat (3) @(posedge ref_clk);
        check(brake_resistor_on, exp);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Whole run is some ninety cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (rows[k]) begin
            acc(rows[k].w, rows[k].i, rows[k].s, 32'h00000000);
            check(rd, rows[k].x);
            check(er, rows[k].e);
        end
        $display("Object table done");
        check(save_settings_tuning, 32'h00000001);
        pwr_step(32'h0000E9CC, 1'b1);
        pwr_step(32'h0000E9CA, 1'b0);
        pwr_step(32'hFFFFF000, 1'b0);
        acc(1'b1, 16'h4021, 8'h02, 32'h0000E000);
        pwr_step(32'h0000E9CA, 1'b1);
        acc(1'b1, 16'h4021, 8'h01, 32'h00000000);
        pwr_step(32'h0000F000, 1'b0);
        check(save_settings_tuning, 32'h00000000);
        $display("Brake resistor done");
        @(posedge ref_clk);
        error_push <= 1'b1;
        error_entry <= 32'h5A5A8130;
        @(posedge ref_clk);
        error_push <= 1'b0;
        acc(1'b0, 16'h603F, 8'h00, 32'h00000000);
        check(rd, 32'h00008130);
        acc(1'b1, 16'h6040, 8'h00, 32'h00000080);
        check(fault_clear_pulse, 1'b1);
        acc(1'b0, 16'h603F, 8'h00, 32'h00000000);
        check(rd, 32'h00000000);
        check(drive_control_word, 16'h0080);
        acc(1'b1, 16'h6040, 8'h00, 32'h00000080);
        check(fault_clear_pulse, 1'b0);
        acc(1'b0, 16'h4041, 8'h00, 32'h00000000);
        check(rd, 32'h0000C0DE);
        $display("Control word done");
        @(posedge ref_clk);
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        acc(1'b0, 16'h4021, 8'h02, 32'h00000000);
        check(rd, 32'h0000EBBF);
        check(drive_control_word, 16'h0000);
        $display("Reset done");
        fork
            acc(1'b1, 16'h6040, 8'h00, 32'h00000080);
            begin
                @(posedge ref_clk);
                error_push <= 1'b1;
                error_entry <= 32'h00001234;
                @(posedge ref_clk);
                error_push <= 1'b0;
            end
        join
        check(fault_clear_pulse, 1'b1);
        acc(1'b0, 16'h603F, 8'h00, 32'h00000000);
        check(rd, 32'h00001234);
        acc(1'b1, 16'h6040, 8'h00, 32'h00000000);
        acc(1'b1, 16'h6040, 8'h01, 32'h00000080);
        check(er, 1'b1);
        check(fault_clear_pulse, 1'b0);
        acc(1'b0, 16'h603F, 8'h00, 32'h00000000);
        check(rd, 32'h00001234);
        check(drive_control_word, 16'h0000);
        $display("Fault clear done");
        summarize();
    end
endmodule
bind drive_monitor_config_objects drive_objects_sva u_sva (.*);
